/* tcg_consts.svh */
// Register offsets, field positions, mode codes and reset values of the timer configuration guard
`ifndef TCG_CONSTS_SVH
`define TCG_CONSTS_SVH
`define TCG_OFS_CTL0 8'h00
`define TCG_OFS_CTL1 8'h04
`define TCG_OFS_IOC0 8'h08
`define TCG_OFS_IOC1 8'h0c
`define TCG_OFS_IOC2 8'h10
`define TCG_OFS_OPT0 8'h14
`define TCG_OFS_STAT 8'h18
`define TCG_OFS_CCR0 8'h1c
`define TCG_CE_BIT 7
`define TCG_CKS_LSB 0
`define TCG_CKS_MSB 2
`define TCG_MD_LSB 0
`define TCG_MD_MSB 2
`define TCG_EEE_BIT 5
`define TCG_EST_BIT 6
`define TCG_OL0_BIT 1
`define TCG_OE0_BIT 0
`define TCG_OL1_BIT 3
`define TCG_OE1_BIT 2
`define TCG_IS_LSB 0
`define TCG_IS_MSB 3
`define TCG_ETS_LSB 0
`define TCG_ETS_MSB 1
`define TCG_EES_LSB 2
`define TCG_EES_MSB 3
`define TCG_OVF_BIT 0
`define TCG_CCS_LSB 4
`define TCG_CCS_MSB 5
`define TCG_OPT_WMASK 8'h31
`define TCG_CTL0_WMASK 8'h87
`define TCG_CTL1_WMASK 8'h27
`define TCG_IOC0_WMASK 8'h0f
`define TCG_MD_FREE 3'h0
`define TCG_MD_EVT 3'h1
`define TCG_MD_TRIG 3'h2
`define TCG_MD_ONESHOT 3'h3
`define TCG_MD_PWM_MEAS 3'h6
`define TCG_RST_BYTE 8'h00
`define TCG_RST_WORD 16'h0000
`define TCG_ADDR_MSB 7
`define TCG_SLOW_ERR 2'h1
`endif

/* tcg_pkg.sv */
// Types shared by the timer configuration guard
package tcg_pkg;
  typedef struct packed {
    logic [2:0] prescale;
    logic [2:0] mode;
    logic event_sel;
    logic [3:0] cap_edge;
    logic [1:0] evt_edge;
    logic [1:0] trig_edge;
    logic cap_en;
    logic evt_en;
    logic trig_en;
    logic ext_count_src;
  } tcg_eff_t;
  typedef enum logic [2:0] {
    TCG_IDLE = 3'b001,
    TCG_DATA = 3'b010,
    TCG_DONE = 3'b100
  } tcg_phase_t;
endpackage

/* tcg_ccr_mem.sv */
// Capture/compare register 0 store with registered read data
module tcg_ccr_mem (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data
);
`include "tcg_consts.svh"
  logic [15:0] store;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      store <= `TCG_RST_WORD;
      rd_data <= `TCG_RST_WORD;
    end else begin
      if (wr_en) begin
        store <= wr_data;
      end
      rd_data <= wr_en ? wr_data : store;
    end
  end
endmodule

/* tcg_top.sv */
// AHB-Lite configuration registers with run-enable write guard and mode qualification
module tcg_top (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic cpu_slow_clock,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output tcg_pkg::tcg_eff_t eff_cfg,
  output logic count_run_enable,
  output logic software_trigger_pulse,
  output logic timer_output_pin_ch0,
  output logic timer_output_pin_oe_n_ch0,
  output logic timer_output_pin_ch1,
  output logic timer_output_pin_oe_n_ch1
);
  import tcg_pkg::*;
`include "tcg_consts.svh"

  typedef struct packed {
    tcg_phase_t phase;
    logic wr;
    logic [`TCG_ADDR_MSB:0] addr;
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [7:0] ioc0;
    logic [7:0] ioc1;
    logic [7:0] ioc2;
    logic [7:0] opt0;
    logic [1:0] blocked;
    logic [31:0] rdata;
    tcg_eff_t eff;
    logic trig;
    logic pin0;
    logic pin1;
    logic oen0;
    logic oen1;
    logic rdy;
  } tcg_state_t;

  tcg_state_t st, next_st;
  logic [15:0] ccr_rd;
  logic ccr_we;

  // Keep bits in keep_mask at old value when running, take new value otherwise
  function automatic logic [7:0] guard(input logic [7:0] old_v, input logic [7:0] new_v,
                                       input logic [7:0] keep_mask, input logic run);
    guard = run ? ((old_v & keep_mask) | (new_v & ~keep_mask)) : new_v;
  endfunction

  function automatic logic [7:0] bitmask(input int lo, input int hi);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (i >= lo && i <= hi) begin
        m[i] = 1'b1;
      end
    end
    bitmask = m;
  endfunction

  tcg_ccr_mem u_ccr (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .wr_en(ccr_we),
    .wr_data(hwdata[15:0]),
    .rd_data(ccr_rd)
  );

  always_comb begin
    logic run;
    logic [7:0] wd;
    logic changed;
    logic [7:0] keep;
    logic [2:0] md;
    run = 1'b0;
    wd = 8'h00;
    changed = 1'b0;
    keep = 8'h00;
    md = 3'h0;
    next_st = st;
    ccr_we = 1'b0;
    next_st.trig = 1'b0;
    run = st.ctl0[`TCG_CE_BIT];
    wd = hwdata[7:0];
    case (st.phase)
      TCG_IDLE: begin
        if (hsel && hready && htrans[1]) begin
          next_st.phase = TCG_DATA;
          next_st.wr = hwrite;
          next_st.addr = haddr[`TCG_ADDR_MSB:0];
        end
      end
      TCG_DATA: begin
        next_st.phase = TCG_DONE;
        next_st.rdata = 32'h00000000;
        if (st.wr) begin
          case (st.addr)
            `TCG_OFS_CTL0: begin
              // Prescale guarded only while already running; accepted with the 0->1 write
              keep = bitmask(`TCG_CKS_LSB, `TCG_CKS_MSB);
              next_st.ctl0 = guard(st.ctl0, wd, keep, run) & `TCG_CTL0_WMASK;
            end
            `TCG_OFS_CTL1: begin
              keep = bitmask(`TCG_MD_LSB, `TCG_MD_MSB) | bitmask(`TCG_EEE_BIT, `TCG_EEE_BIT);
              next_st.ctl1 = guard(st.ctl1, wd, keep, run) & `TCG_CTL1_WMASK;
              changed = run && (((wd ^ st.ctl1) & keep) != 8'h00);
              md = next_st.ctl1[`TCG_MD_MSB:`TCG_MD_LSB];
              if (wd[`TCG_EST_BIT] && (md == `TCG_MD_TRIG || md == `TCG_MD_ONESHOT)) begin
                next_st.trig = 1'b1;
              end
            end
            `TCG_OFS_IOC0: begin
              keep = `TCG_IOC0_WMASK;
              next_st.ioc0 = guard(st.ioc0, wd, keep, run) & `TCG_IOC0_WMASK;
              changed = run && (((wd ^ st.ioc0) & keep) != 8'h00);
            end
            `TCG_OFS_IOC1: begin
              keep = bitmask(`TCG_IS_LSB, `TCG_IS_MSB);
              next_st.ioc1 = guard(st.ioc1, wd, keep, run) & keep;
              changed = run && (((wd ^ st.ioc1) & keep) != 8'h00);
            end
            `TCG_OFS_IOC2: begin
              keep = bitmask(`TCG_ETS_LSB, `TCG_EES_MSB);
              next_st.ioc2 = guard(st.ioc2, wd, keep, run) & keep;
              changed = run && (((wd ^ st.ioc2) & keep) != 8'h00);
            end
            `TCG_OFS_OPT0: begin
              // Reserved option bits never stored; overflow flag is write-zero-to-clear
              keep = bitmask(`TCG_CCS_LSB, `TCG_CCS_MSB);
              next_st.opt0 = guard(st.opt0, wd, keep, run) & `TCG_OPT_WMASK;
              next_st.opt0[`TCG_OVF_BIT] = st.opt0[`TCG_OVF_BIT] & wd[`TCG_OVF_BIT];
              changed = run && (((wd ^ st.opt0) & keep) != 8'h00);
            end
            `TCG_OFS_CCR0: begin
              ccr_we = !cpu_slow_clock;
            end
            `TCG_OFS_STAT: begin
              next_st.blocked = 2'h0;
            end
            default: begin
            end
          endcase
          if (changed) begin
            next_st.blocked[0] = 1'b1;
          end
          if (st.addr == `TCG_OFS_CCR0 && cpu_slow_clock) begin
            next_st.blocked[1] = 1'b1;
          end
        end else begin
          case (st.addr)
            `TCG_OFS_CTL0: next_st.rdata = {24'h000000, st.ctl0};
            `TCG_OFS_CTL1: next_st.rdata = {24'h000000, st.ctl1};
            `TCG_OFS_IOC0: next_st.rdata = {24'h000000, st.ioc0};
            `TCG_OFS_IOC1: next_st.rdata = {24'h000000, st.ioc1};
            `TCG_OFS_IOC2: next_st.rdata = {24'h000000, st.ioc2};
            `TCG_OFS_OPT0: next_st.rdata = {24'h000000, st.opt0};
            `TCG_OFS_STAT: next_st.rdata = {29'h00000000, st.blocked, run};
            `TCG_OFS_CCR0: next_st.rdata = {16'h0000, ccr_rd};
            default: next_st.rdata = 32'h00000000;
          endcase
          if (st.addr == `TCG_OFS_CCR0 && cpu_slow_clock) begin
            next_st.rdata = 32'h00000000;
            next_st.blocked[1] = 1'b1;
          end
        end
      end
      TCG_DONE: begin
        next_st.phase = TCG_IDLE;
        if (hsel && hready && htrans[1]) begin
          next_st.phase = TCG_DATA;
          next_st.wr = hwrite;
          next_st.addr = haddr[`TCG_ADDR_MSB:0];
        end
      end
      default: begin
        next_st.phase = TCG_IDLE;
      end
    endcase
    md = next_st.ctl1[`TCG_MD_MSB:`TCG_MD_LSB];
    next_st.eff.prescale = next_st.ctl0[`TCG_CKS_MSB:`TCG_CKS_LSB];
    next_st.eff.mode = md;
    next_st.eff.event_sel = next_st.ctl1[`TCG_EEE_BIT];
    next_st.eff.ext_count_src = next_st.ctl1[`TCG_EEE_BIT] || md == `TCG_MD_EVT;
    next_st.eff.cap_en = md == `TCG_MD_FREE || md == `TCG_MD_PWM_MEAS;
    next_st.eff.cap_edge = next_st.eff.cap_en ? next_st.ioc1[`TCG_IS_MSB:`TCG_IS_LSB] : 4'h0;
    next_st.eff.evt_en = next_st.eff.ext_count_src;
    next_st.eff.evt_edge = next_st.eff.evt_en ?
                           next_st.ioc2[`TCG_EES_MSB:`TCG_EES_LSB] : 2'h0;
    next_st.eff.trig_en = md == `TCG_MD_TRIG || md == `TCG_MD_ONESHOT;
    next_st.eff.trig_edge = next_st.eff.trig_en ?
                            next_st.ioc2[`TCG_ETS_MSB:`TCG_ETS_LSB] : 2'h0;
    // Level bit reaches the pin regardless of run enable or output enable
    next_st.pin0 = next_st.ioc0[`TCG_OL0_BIT];
    next_st.pin1 = next_st.ioc0[`TCG_OL1_BIT];
    next_st.oen0 = !next_st.ioc0[`TCG_OE0_BIT];
    next_st.oen1 = !next_st.ioc0[`TCG_OE1_BIT];
    // Ready comes from a flop so the bus sees no decode glitch
    next_st.rdy = next_st.phase != TCG_DATA;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.phase <= TCG_IDLE;
      st.oen0 <= 1'b1;
      st.oen1 <= 1'b1;
      st.rdy <= 1'b1;
      // All-zero mode is free-running, so capture is qualified from reset on
      st.eff.cap_en <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata = st.rdata;
  assign hreadyout = st.rdy;
  assign hresp = 1'b0;
  assign eff_cfg = st.eff;
  assign count_run_enable = st.ctl0[`TCG_CE_BIT];
  assign software_trigger_pulse = st.trig;
  assign timer_output_pin_ch0 = st.pin0;
  assign timer_output_pin_oe_n_ch0 = st.oen0;
  assign timer_output_pin_ch1 = st.pin1;
  assign timer_output_pin_oe_n_ch1 = st.oen1;
endmodule

/* tcg_props.sv */
// Concurrent checks on the qualified configuration and guarded outputs
module tcg_props (
  input wire logic ref_clk,
  input wire logic rstn,
  input tcg_pkg::tcg_eff_t eff_cfg,
  input wire logic count_run_enable,
  input wire logic software_trigger_pulse,
  input wire logic timer_output_pin_ch0,
  input wire logic timer_output_pin_oe_n_ch0,
  input wire logic timer_output_pin_ch1,
  input wire logic timer_output_pin_oe_n_ch1
);
  timeunit 1ns;
  timeprecision 100ps;
  import tcg_pkg::*;
  tcg_eff_t e;
  logic [3:0] pins;
  assign e = eff_cfg;
  assign pins = {timer_output_pin_ch1, timer_output_pin_oe_n_ch1,
                 timer_output_pin_ch0, timer_output_pin_oe_n_ch0};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_ext_source: assert property (e.mode == 3'h1 |-> e.ext_count_src)
    else $error("event count mode lacks external source");
  a_cap_qualify: assert property (e.cap_en == (e.mode inside {3'h0, 3'h6})
    && (e.cap_en || e.cap_edge == 4'h0)) else $error("capture edges wrongly qualified");
  a_evt_qualify: assert property (e.evt_en == (e.event_sel || e.mode == 3'h1)
    && (e.evt_en || e.evt_edge == 2'h0)) else $error("event edges wrongly qualified");
  a_trig_qualify: assert property (e.trig_en == (e.mode inside {3'h2, 3'h3})
    && (e.trig_en || e.trig_edge == 2'h0)) else $error("trigger edges wrongly qualified");
  a_trig_gate: assert property (software_trigger_pulse |-> e.trig_en ##1
    !software_trigger_pulse) else $error("software trigger outside trigger modes");
  a_guard_cfg: assert property (count_run_enable && $past(count_run_enable) |->
    $stable({e.mode, e.event_sel, e.cap_edge, e.evt_edge, e.trig_edge}))
    else $error("guarded field changed while running");
  a_guard_pins: assert property (count_run_enable && $past(count_run_enable) |->
    $stable(pins)) else $error("output bits changed while running");
  a_prescale_hold: assert property ($past(count_run_enable) |->
    $stable(e.prescale)) else $error("prescale changed while running");
  cover property ($rose(count_run_enable));
  cover property (software_trigger_pulse);
  cover property (count_run_enable && e.cap_en);
endmodule
bind tcg_top tcg_props tcg_props_inst (.*);

/* tcg_top_tb_top.sv */
// Directed register sequences for the configuration guard over AHB-Lite
`include "tcg_consts.svh"
module tcg_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import tcg_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic cpu_slow_clock = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, count_run_enable, software_trigger_pulse;
  logic timer_output_pin_ch0, timer_output_pin_oe_n_ch0;
  logic timer_output_pin_ch1, timer_output_pin_oe_n_ch1;
  wire logic hready = hreadyout;
  wire [3:0] pins = {timer_output_pin_ch1, timer_output_pin_oe_n_ch1,
                     timer_output_pin_ch0, timer_output_pin_oe_n_ch0};
  tcg_eff_t eff_cfg;
  int failures = 0;
  int check_count = 0;
  int trig_seen = 0;
  int n;
  logic [2:0] m;
  logic es, cx, ev, tx;
  tcg_top tcg_top_inst (.*);
  always #12.5 ref_clk = ~ref_clk;
  always @(negedge ref_clk) if (software_trigger_pulse === 1'b1) trig_seen++;
  task automatic complete_run;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // Extra edge lets the written outputs settle before they are compared
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
    @(posedge ref_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0, r);
    chk(nm, x, r);
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    rchk("ctl0", `TCG_OFS_CTL0, 32'h0);
    rchk("unmapped", 8'h40, 32'h0);
    chk("pins", 32'h5, pins);
    wr(`TCG_OFS_IOC0, 32'h0a);
    chk("pins", 32'hf, pins);
    wr(`TCG_OFS_IOC0, 32'h05);
    chk("pins", 32'h0, pins);
    $display("test pins done");
    wr(`TCG_OFS_IOC1, 32'hf);
    wr(`TCG_OFS_IOC2, 32'hf);
    for (int i = 0; i < 9; i++) begin
      m = (i < 8) ? i[2:0] : 3'h0;
      es = (i == 8);
      cx = m inside {3'h0, 3'h6};
      ev = es || m == 3'h1;
      tx = m inside {3'h2, 3'h3};
      wr(`TCG_OFS_CTL1, {26'h0, es, 2'h0, m});
      n = trig_seen;
      wr(`TCG_OFS_CTL1, {25'h0, 1'b1, es, 2'h0, m});
      chk("cap", {cx, cx ? 4'hf : 4'h0}, {eff_cfg.cap_en, eff_cfg.cap_edge});
      chk("evt", {ev, ev ? 2'h3 : 2'h0}, {eff_cfg.evt_en, eff_cfg.evt_edge});
      chk("trig", {tx, tx ? 2'h3 : 2'h0}, {eff_cfg.trig_en, eff_cfg.trig_edge});
      chk("pulse", tx, trig_seen - n);
      if (m == 3'h1) chk("source", 32'h1, eff_cfg.ext_count_src);
    end
    $display("test modes done");
    wr(`TCG_OFS_STAT, 32'h0);
    wr(`TCG_OFS_CCR0, 32'h1234);
    cpu_slow_clock <= 1'b1;
    wr(`TCG_OFS_CCR0, 32'h5678);
    rchk("ccr0 slow", `TCG_OFS_CCR0, 32'h0);
    cpu_slow_clock <= 1'b0;
    rchk("ccr0", `TCG_OFS_CCR0, 32'h1234);
    rchk("stat", `TCG_OFS_STAT, 32'h4);
    wr(`TCG_OFS_OPT0, 32'hff);
    rchk("opt", `TCG_OFS_OPT0, 32'h30);
    $display("test ccr0 and option done");
    wr(`TCG_OFS_CTL0, 32'h85);
    chk("start", 32'hd, {count_run_enable, eff_cfg.prescale});
    wr(`TCG_OFS_CTL0, 32'h83);
    wr(`TCG_OFS_CTL1, 32'h06);
    wr(`TCG_OFS_IOC0, 32'h0a);
    wr(`TCG_OFS_OPT0, 32'h0);
    chk("held", {3'h5, 3'h0, 1'b1}, {eff_cfg.prescale, eff_cfg.mode, eff_cfg.event_sel});
    chk("pins held", 32'h0, pins);
    rchk("opt held", `TCG_OFS_OPT0, 32'h30);
    rchk("stat", `TCG_OFS_STAT, 32'h7);
    wr(`TCG_OFS_STAT, 32'h0);
    wr(`TCG_OFS_CTL1, 32'h20);
    rchk("stat same", `TCG_OFS_STAT, 32'h1);
    wr(`TCG_OFS_CTL0, 32'h0);
    wr(`TCG_OFS_CTL1, 32'h06);
    chk("mode", {1'b0, 3'h6, 1'b1}, {count_run_enable, eff_cfg.mode, eff_cfg.cap_en});
    chk("hresp", 32'h0, hresp);
    $display("test guard done");
    complete_run();
  end
endmodule
